// ### design/pmt_debounce.sv
`timescale 1ns/1ps
module pmt_debounce
  import pmt_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic [NUM_IN-1:0] raw_n_i,
  pmt_in_if.src                  ins
);
  // ----------------------------------------
  // Sync and filter
  // ----------------------------------------
  logic [NUM_IN-1:0] meta_n;
  logic [NUM_IN-1:0] sync_n;
  logic [NUM_IN-1:0] state;
  logic [NUM_IN-1:0] pulse;
  logic [25:0]       cnt [NUM_IN];

  // RQ12 two-flop sync
  always_ff @(posedge ref_clk_i) begin
    meta_n <= raw_n_i;
    sync_n <= meta_n;
  end

  // RQ12 stable-time filter; RQ7 low means strapped
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (reset_i) begin
        state[i] <= 1'b0;
        cnt[i]   <= '0;
        pulse[i] <= 1'b0;
      end else begin
        pulse[i] <= 1'b0;
        if (~sync_n[i] == state[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] == 26'(DEB_CYCLES - 1)) begin
          cnt[i]   <= '0;
          state[i] <= ~sync_n[i];
          pulse[i] <= ~sync_n[i];
        end else begin
          cnt[i] <= cnt[i] + 26'h1;
        end
      end
    end
  end

  assign ins.level = state;
  assign ins.press = pulse;
endmodule // pmt_debounce

// ### design/pmt_in_if.sv
`timescale 1ns/1ps
// Debounced input levels and press pulses
interface pmt_in_if;
  import pmt_pkg::*;
  logic [NUM_IN-1:0] level;
  logic [NUM_IN-1:0] press;
  modport src (output level, output press);
  modport dst (input level, input press);
endinterface // pmt_in_if

// ### design/pmt_pkg.sv
// Contract
// RQ1 - Pressing program and digit-one together enters user programming mode, display alternating calibration and programming labels.
// RQ2 - In programming mode each program press advances one menu item up to the third config code, and two more presses return to operation.
// RQ3 - Tare is enabled when the first digit of the third config code is set to three.
// RQ4 - While tare is enabled a program press lights the rightmost decimal point.
// RQ5 - While tare is enabled each program press captures the reading as offset so the shown value becomes zero.
// RQ6 - Pressing up and right together disables tare, drops the offset and shows the untared reading.
// RQ7 - A rear input is active only while strapped to common, and inactive when open.
// RQ8 - While lockout is asserted parameters may be viewed but never changed.
// RQ9 - While hold is asserted the display freezes but conversions go on, and release shows the latest reading at once.
// RQ10 - A momentary test input lights all segments, five eights, for three seconds.
// RQ11 - During the three-second test the processing logic is held in reset.
// RQ12 - Every button and rear input is synchronised and debounced so one closure gives one command.
package pmt_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned TEST_MS        = 3000;
  localparam int unsigned TEST_CYCLES    = TEST_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned LABEL_MS       = 500;
  localparam int unsigned LABEL_CYCLES   = LABEL_MS * (CLK_HZ / 1000);
  // ----------------------------------------
  // Menu and display
  // ----------------------------------------
  localparam int unsigned MENU_LAST      = 3;          // Third config code item
  localparam logic [3:0]  TARE_DIGIT     = 4'h3;
  localparam logic [3:0]  CODE3_RESET    = 4'h0;
  localparam int unsigned RDG_W          = 17;
  localparam int unsigned NUM_IN         = 7;
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;
  // Input index map
  localparam int unsigned IN_PROG        = 0;
  localparam int unsigned IN_ONE         = 1;
  localparam int unsigned IN_UP          = 2;
  localparam int unsigned IN_RIGHT       = 3;
  localparam int unsigned IN_LOCK        = 4;
  localparam int unsigned IN_HOLD        = 5;
  localparam int unsigned IN_TEST        = 6;

  typedef enum logic [1:0] {PMT_LBL_NONE, PMT_LBL_HWCAL, PMT_LBL_PROG, PMT_LBL_CODE3} pmt_label_e;
  typedef enum {PMT_RUN, PMT_ENTRY, PMT_MENU, PMT_EXIT} pmt_state_e;
endpackage

// ### design/pmt_test_timer.sv
`timescale 1ns/1ps
module pmt_test_timer
  import pmt_pkg::*;
#(
  parameter int unsigned TEST_LEN = TEST_CYCLES
)
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      active_o
);
  logic [27:0] cnt;

  // RQ10 fixed three seconds
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt      <= '0;
      active_o <= 1'b0;
    end else if (start_i && !active_o) begin
      cnt      <= 28'(TEST_LEN - 1);
      active_o <= 1'b1;
    end else if (active_o) begin
      if (cnt == '0) begin
        active_o <= 1'b0;
      end else begin
        cnt <= cnt - 28'h1;
      end
    end
  end
endmodule // pmt_test_timer

// ### design/pmt_top.sv
`timescale 1ns/1ps
module pmt_top
  import pmt_pkg::*;
#(
  // Interval lengths in clock cycles; defaults are the real intervals
  parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int unsigned TEST_LEN   = TEST_CYCLES,
  parameter int unsigned LBL_LEN    = LABEL_CYCLES
)
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    btn_prog_n_i,
  input  wire logic                    btn_one_n_i,
  input  wire logic                    btn_up_n_i,
  input  wire logic                    btn_right_n_i,
  input  wire logic                    lockout_n_i,
  input  wire logic                    hold_n_i,
  input  wire logic                    test_n_i,
  input  wire logic                    conv_valid_i,
  input  wire logic signed [RDG_W-1:0] conv_data_i,
  output logic signed [RDG_W-1:0]      shown_value_o,
  output logic                         all_segments_o,
  output logic                         right_dp_o,
  output logic                         tare_enabled_o,
  output logic                         prog_mode_o,
  output logic [1:0]                   label_o,
  output logic [1:0]                   menu_item_o,
  output logic [3:0]                   code3_digit_o,
  output logic                         proc_reset_o
);
  // ----------------------------------------
  // Inputs
  // ----------------------------------------
  pmt_in_if ins ();
  logic     test_active;
  logic     core_rst;

  pmt_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_n_i   ({test_n_i, hold_n_i, lockout_n_i, btn_right_n_i,
                 btn_up_n_i, btn_one_n_i, btn_prog_n_i}),
    .ins       (ins)
  );

  // RQ10 test start from press
  pmt_test_timer #(.TEST_LEN(TEST_LEN)) u_tst (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .start_i   (ins.press[IN_TEST]),
    .active_o  (test_active)
  );

  // RQ11 core reset during test
  assign core_rst     = reset_i | test_active;
  assign proc_reset_o = test_active;

  // Combined press decodes
  logic prog_p, one_p, up_p, right_p, chord_enter, chord_untare, locked;
  assign prog_p  = ins.press[IN_PROG];
  assign one_p   = ins.press[IN_ONE];
  assign up_p    = ins.press[IN_UP];
  assign right_p = ins.press[IN_RIGHT];
  assign locked  = ins.level[IN_LOCK];
  // RQ1 program plus digit-one chord
  assign chord_enter  = (prog_p & ins.level[IN_ONE]) | (one_p & ins.level[IN_PROG]);
  // RQ6 up plus right chord
  assign chord_untare = (up_p & ins.level[IN_RIGHT]) | (right_p & ins.level[IN_UP]);

  // ----------------------------------------
  // Menu state machine
  // ----------------------------------------
  pmt_state_e  state;
  logic [1:0]  item;
  logic [24:0] lbl_cnt;
  logic        lbl_phase;

  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      state    <= PMT_RUN;
      item     <= '0;
    end else begin
      case (state)
        // RQ1 enter programming mode
        PMT_RUN: begin
          if (chord_enter) begin
            state <= PMT_ENTRY;
          end
        end
        // Digit-one press accepts the mode
        PMT_ENTRY: begin
          if (one_p && !ins.level[IN_PROG]) begin
            state <= PMT_MENU;
            item  <= 2'h1;
          end
        end
        // RQ2 advance to third code
        PMT_MENU: begin
          if (prog_p) begin
            if (item == 2'(MENU_LAST)) begin
              state <= PMT_EXIT;
            end else begin
              item <= item + 2'h1;
            end
          end
        end
        // RQ2 second press returns
        PMT_EXIT: begin
          if (prog_p) begin
            state <= PMT_RUN;
            item  <= '0;
          end
        end
        default: state <= PMT_RUN;
      endcase
    end
  end

  // Label alternation timer
  always_ff @(posedge ref_clk_i) begin
    if (core_rst || state != PMT_ENTRY) begin
      lbl_cnt   <= '0;
      lbl_phase <= 1'b0;
    end else if (lbl_cnt == 25'(LBL_LEN - 1)) begin
      lbl_cnt   <= '0;
      lbl_phase <= ~lbl_phase;
    end else begin
      lbl_cnt <= lbl_cnt + 25'h1;
    end
  end

  // RQ1 alternate calibration and program labels
  always_comb begin
    case (state)
      PMT_ENTRY: label_o = lbl_phase ? 2'(PMT_LBL_PROG) : 2'(PMT_LBL_HWCAL);
      PMT_MENU:  label_o = (item == 2'(MENU_LAST)) ? 2'(PMT_LBL_CODE3) : 2'(PMT_LBL_NONE);
      PMT_EXIT:  label_o = 2'(PMT_LBL_CODE3);
      default:   label_o = 2'(PMT_LBL_NONE);
    endcase
  end

  assign prog_mode_o = (state != PMT_RUN);
  assign menu_item_o = item;

  // ----------------------------------------
  // Config code digit
  // ----------------------------------------
  logic [3:0] code3;
  logic       on_code3;
  assign on_code3 = (state == PMT_MENU) && (item == 2'(MENU_LAST));

  // RQ8 edits refused while locked
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      code3 <= CODE3_RESET;
    end else if (on_code3 && !locked && up_p && !ins.level[IN_RIGHT]) begin
      code3 <= (code3 == DIGIT_MAX) ? 4'h0 : code3 + 4'h1;
    end else if (!prog_mode_o && !locked && chord_untare) begin
      // RQ6 clear tare selection
      code3 <= CODE3_RESET;
    end
  end
  assign code3_digit_o = code3;

  // RQ3 tare enabled by digit three
  logic tare_en;
  assign tare_en        = (code3 == TARE_DIGIT);
  assign tare_enabled_o = tare_en;

  // ----------------------------------------
  // Reading path
  // ----------------------------------------
  logic signed [RDG_W-1:0] latest;
  logic signed [RDG_W-1:0] offset;
  logic                    dp;

  // RQ9 conversions run regardless of hold
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      latest <= '0;
    end else if (conv_valid_i) begin
      latest <= conv_data_i;
    end
  end

  // RQ5 capture offset on tare press
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      offset <= '0;
      dp     <= 1'b0;
    end else if (!tare_en || (!prog_mode_o && chord_untare)) begin
      // RQ6 drop offset
      offset <= '0;
      dp     <= 1'b0;
    end else if (!prog_mode_o && prog_p && !chord_enter) begin
      offset <= latest;
      // RQ4 decimal point on
      dp     <= 1'b1;
    end
  end

  // RQ9 freeze while hold, release shows latest
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      shown_value_o <= '0;
    end else if (!ins.level[IN_HOLD]) begin
      shown_value_o <= RDG_W'(latest - offset);
    end
  end

  assign right_dp_o     = dp;
  // RQ10 all segments lit
  assign all_segments_o = test_active;
endmodule // pmt_top

// ### dv/pmt_panel.sv
`timescale 1ns/1ps
module pmt_panel
  import pmt_pkg::*;
(
  output logic [NUM_IN-1:0] raw_n_o
);
  logic [NUM_IN-1:0] closed = '0;
  assign raw_n_o = ~closed;
  // Close or open one contact
  task automatic set(input int idx, input logic c);
    closed[idx] = c;
  endtask
endmodule // pmt_panel

// ### dv/pmt_props.sv
`timescale 1ns/1ps
module pmt_props
  import pmt_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES
)
(
  input wire logic                    ref_clk_i,
  input wire logic                    reset_i,
  input wire logic                    lockout_n_i,
  input wire logic                    conv_valid_i,
  input wire logic signed [RDG_W-1:0] shown_value_o,
  input wire logic                    all_segments_o,
  input wire logic                    right_dp_o,
  input wire logic                    tare_enabled_o,
  input wire logic                    prog_mode_o,
  input wire logic [1:0]              label_o,
  input wire logic [3:0]              code3_digit_o,
  input wire logic                    proc_reset_o
);
  logic [19:0] lock_cnt;
  // Cycles the lockout strap has stayed closed
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || lockout_n_i) lock_cnt <= 20'h0;
    else if (lock_cnt != 20'hfffff) lock_cnt <= lock_cnt + 20'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_tare_taken; $rose(right_dp_o) && !conv_valid_i; endsequence
  sequence s_test_start; $rose(all_segments_o); endsequence
  a_test_holds_reset: assert property (proc_reset_o == all_segments_o)
    else $error("processing reset differs from display test");
  a_tare_from_code: assert property (tare_enabled_o == (code3_digit_o == TARE_DIGIT))
    else $error("tare enable does not follow code digit");
  a_dp_needs_tare: assert property (right_dp_o |-> tare_enabled_o)
    else $error("decimal point lit without tare");
  a_tare_zeroes: assert property (s_tare_taken |=> shown_value_o == '0)
    else $error("reading not zero after tare");
  a_locked_stable: assert property ((lock_cnt > 20'(DEB_CYCLES + 4)) && prog_mode_o
    |=> $stable(code3_digit_o)) else $error("code changed while locked");
  a_digit_range: assert property (code3_digit_o <= DIGIT_MAX)
    else $error("code digit out of range");
  a_test_span: assert property (s_test_start |-> all_segments_o [*8])
    else $error("display test ended early");
  a_entry_label: assert property ($rose(prog_mode_o) |-> label_o inside {2'h1, 2'h2})
    else $error("wrong label on entry");
  a_test_clears: assert property (s_test_start |=> !prog_mode_o && shown_value_o == '0)
    else $error("core not cleared during test");
  a_core_held: assert property (proc_reset_o && $past(proc_reset_o) |->
    !prog_mode_o && !right_dp_o && shown_value_o == '0) else $error("core ran during test");
endmodule // pmt_props
bind pmt_top pmt_props #(.DEB_CYCLES(DEB_CYCLES)) i_pmt_props (.ref_clk_i, .reset_i,
  .lockout_n_i, .conv_valid_i,
  .shown_value_o, .all_segments_o, .right_dp_o, .tare_enabled_o, .prog_mode_o, .label_o,
  .code3_digit_o, .proc_reset_o);

// ### dv/pmt_top_tb_top.sv
`timescale 1ns/1ps
module pmt_top_tb_top;
  import pmt_pkg::*;
  // Short intervals so the whole run stays brief
  localparam int unsigned TB_DEB   = 16;
  localparam int unsigned TB_TEST  = 200;
  localparam int unsigned TB_LBL   = 8;
  localparam int          TB_LIMIT = 5000;
  logic                    ref_clk_i = 1'b0;
  logic                    reset_i = 1'b1;
  logic                    conv_valid_i = 1'b0;
  logic signed [RDG_W-1:0] conv_data_i = '0;
  logic [NUM_IN-1:0]       raw_n;
  logic signed [RDG_W-1:0] shown_value_o;
  logic                    all_segments_o, right_dp_o, tare_enabled_o, prog_mode_o, proc_reset_o;
  logic [1:0]              label_o, menu_item_o;
  logic [3:0]              code3_digit_o;
  int                      n_errors = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  // Clock
  always #12.5 ref_clk_i = ~ref_clk_i;
  pmt_panel i_pmt_panel (.raw_n_o(raw_n));
  pmt_top #(.DEB_CYCLES(TB_DEB), .TEST_LEN(TB_TEST), .LBL_LEN(TB_LBL)) i_pmt_top (
    .ref_clk_i, .reset_i, .btn_prog_n_i(raw_n[IN_PROG]),
    .btn_one_n_i(raw_n[IN_ONE]), .btn_up_n_i(raw_n[IN_UP]), .btn_right_n_i(raw_n[IN_RIGHT]),
    .lockout_n_i(raw_n[IN_LOCK]), .hold_n_i(raw_n[IN_HOLD]), .test_n_i(raw_n[IN_TEST]),
    .conv_valid_i, .conv_data_i, .shown_value_o, .all_segments_o, .right_dp_o,
    .tare_enabled_o, .prog_mode_o, .label_o, .menu_item_o, .code3_digit_o, .proc_reset_o);
  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [RDG_W-1:0] seen, input logic [RDG_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Move one contact, then wait out the debounce
  task automatic act(input int idx, input logic c);
    i_pmt_panel.set(idx, c);
    repeat (TB_DEB + 8) @(negedge ref_clk_i);
  endtask
  task automatic tap(input int idx);
    act(idx, 1'b1);
    act(idx, 1'b0);
  endtask
  task automatic conv(input int v);
    conv_valid_i = 1'b1;
    conv_data_i = RDG_W'(v);
    @(negedge ref_clk_i);
    conv_valid_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  // Enter menu, refused edit under lockout, set tare digit, leave
  task automatic t_menu;
    act(IN_PROG, 1'b1);
    act(IN_ONE, 1'b1);
    chk("prog_mode", RDG_W'(prog_mode_o), 1);
    chk("entry label", RDG_W'(label_o), RDG_W'(PMT_LBL_HWCAL));
    repeat (TB_LBL) @(negedge ref_clk_i);
    chk("entry label", RDG_W'(label_o), RDG_W'(PMT_LBL_PROG));
    i_pmt_panel.set(IN_PROG, 1'b0);
    act(IN_ONE, 1'b0);
    tap(IN_ONE);
    chk("menu item", RDG_W'(menu_item_o), 1);
    tap(IN_PROG);
    tap(IN_PROG);
    chk("menu item", RDG_W'(menu_item_o), 3);
    chk("code label", RDG_W'(label_o), RDG_W'(PMT_LBL_CODE3));
    act(IN_LOCK, 1'b1);
    tap(IN_UP);
    chk("locked digit", RDG_W'(code3_digit_o), 0);
    act(IN_LOCK, 1'b0);
    repeat (3) tap(IN_UP);
    chk("code digit", RDG_W'(code3_digit_o), 3);
    chk("tare enabled", RDG_W'(tare_enabled_o), 1);
    tap(IN_PROG);
    tap(IN_PROG);
    chk("prog_mode", RDG_W'(prog_mode_o), 0);
  endtask
  // Tare on each press, then clear by chord
  task automatic t_tare;
    conv(100);
    chk("shown", shown_value_o, 100);
    act(IN_PROG, 1'b1);
    chk("tare dp", RDG_W'(right_dp_o), 1);
    chk("shown", shown_value_o, 0);
    act(IN_PROG, 1'b0);
    conv(150);
    chk("shown", shown_value_o, 50);
    tap(IN_PROG);
    chk("shown", shown_value_o, 0);
    act(IN_UP, 1'b1);
    act(IN_RIGHT, 1'b1);
    i_pmt_panel.set(IN_UP, 1'b0);
    act(IN_RIGHT, 1'b0);
    chk("tare enabled", RDG_W'(tare_enabled_o), 0);
    chk("tare dp", RDG_W'(right_dp_o), 0);
    conv(150);
    chk("shown", shown_value_o, 150);
  endtask
  // Hold freezes reading, display test lights all and resets core
  task automatic t_hold_test;
    act(IN_HOLD, 1'b1);
    conv(200);
    chk("held", shown_value_o, 150);
    act(IN_HOLD, 1'b0);
    chk("released", shown_value_o, 200);
    act(IN_TEST, 1'b1);
    chk("all segments", RDG_W'(all_segments_o), 1);
    chk("proc reset", RDG_W'(proc_reset_o), 1);
    chk("shown", shown_value_o, 0);
    act(IN_TEST, 1'b0);
    chk("all segments", RDG_W'(all_segments_o), 1);
    // Interval runs from debounce edge plus one, for exactly TB_TEST cycles
    repeat (TB_TEST - 30) @(negedge ref_clk_i);
    chk("all segments", RDG_W'(all_segments_o), 1);
    @(negedge ref_clk_i);
    chk("all segments", RDG_W'(all_segments_o), 0);
    chk("proc reset", RDG_W'(proc_reset_o), 0);
    conv(300);
    chk("resumed", shown_value_o, 300);
  endtask
  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == TB_LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    chk("prog_mode", RDG_W'(prog_mode_o), 0);
    t_menu();
    t_tare();
    t_hold_test();
    end_of_test();
  end
endmodule // pmt_top_tb_top
